// ### pkg/pllsp_regs.vh
/*
  Constants of the synthesizer programming logic: APB offsets, serial frame
  lengths, configuration field positions, reset values and timing figures.
  Assumes it is included by bare name, definitions only.
*/
`ifndef PLLSP_REGS_VH
`define PLLSP_REGS_VH

// APB register byte offsets
`define PLLSP_OFF_CTRL 8'h00
`define PLLSP_OFF_STATUS 8'h04
`define PLLSP_OFF_CFG 8'h08
`define PLLSP_OFF_CHAN 8'h0C
`define PLLSP_OFF_REF 8'h10

// Control register fields and reset value
`define PLLSP_CTRL_PORT_EN 0
`define PLLSP_CTRL_FORCE_SBY 1
`define PLLSP_CTRL_RESET 2'h1

// Serial frame lengths that pick the destination register
`define PLLSP_LEN_CFG 6'h08
`define PLLSP_LEN_REF 6'h10
`define PLLSP_LEN_CHAN 6'h18

// Configuration word fields
`define PLLSP_CFG_STANDBY 7
`define PLLSP_CFG_GAIN_HI 6
`define PLLSP_CFG_GAIN_LO 5
`define PLLSP_CFG_DOUT 4
`define PLLSP_CFG_OUTA 3
`define PLLSP_CFG_OUTB 2
`define PLLSP_CFG_REF_OFF 1
`define PLLSP_CFG_LD_OFF 0
`define PLLSP_CFG_RESET 8'h00

// Channel ratio fields: main count above swallow count
`define PLLSP_CHAN_N_HI 17
`define PLLSP_CHAN_N_LO 6
`define PLLSP_CHAN_A_HI 5
`define PLLSP_CHAN_A_LO 0
`define PLLSP_CHAN_RESET 24'h000040

// Reference ratio: low 13 bits, smallest divide other than one
`define PLLSP_REF_RESET 16'h0001
`define PLLSP_REF_MIN 13'h0005

// Prescaler moduli
`define PLLSP_PRE_LOW 7'h40
`define PLLSP_PRE_HIGH 7'h41

// Serial rate: fastest bit period in ns and core clock period in ns
`define PLLSP_SCLK_MIN_NS 250
`define PLLSP_CORE_NS 5
`define PLLSP_SCLK_MIN_CYC (`PLLSP_SCLK_MIN_NS / `PLLSP_CORE_NS)

`endif

// ### logic/pllsp_divider.v
/*
  Programmable down-counting divider used for the reference and main counters.
  Assumes count pulses are one-cycle enables on the core clock.
*/
`timescale 1ns/10ps
module pllsp_divider #(
  parameter W = 13
) (
  input wire core_clk_i,
  input wire resetn_i,
  input wire restart_i,
  input wire count_i,
  input wire [W-1:0] ratio_i,
  output wire tc_o
);
  reg [W-1:0] cnt_reg;

  // Terminal count when the last pulse of the period arrives
  assign tc_o = count_i & (cnt_reg <= {{(W-1){1'b0}}, 1'b1});

  // Reload on terminal count so every period uses the current ratio
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_reg <= {W{1'b0}};
    end else if (restart_i) begin
      cnt_reg <= ratio_i;
    end else if (tc_o) begin
      cnt_reg <= ratio_i;
    end else if (count_i) begin
      cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule

// ### logic/pllsp_core.v
/*
  Serial programming and divider logic of a frequency synthesizer, with an
  APB slave for control and observation.
  Assumes serial and divider inputs arrive asynchronously from pins and are
  much slower than the 200 MHz core clock; APB runs on the core clock.
*/
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/10ps
`include "pllsp_regs.vh"

module pllsp_core (
  input wire core_clk_i,
  input wire resetn_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire ser_data_i,
  input wire ser_clk_i,
  input wire frame_select_n_i,
  input wire ref_in_i,
  input wire rf_in_i,
  output wire ref_out_o,
  output wire ref_div_o,
  output wire vco_div_o,
  output wire lock_detect_o,
  output wire [1:0] pd_gain_o,
  output wire output_a_o,
  output wire output_b_o,
  output wire output_b_oe_o
);
  // Synchronisers and edge history for pin inputs
  reg [2:0] sclk_sync_reg;
  reg [2:0] fs_sync_reg;
  reg [1:0] din_sync_reg;
  reg [2:0] ref_sync_reg;
  reg [2:0] rf_sync_reg;
  // Serial shifter
  reg [23:0] shift_reg;
  reg [5:0] bit_cnt_reg;
  reg dout_reg;
  // Programmed registers and buffers
  reg [1:0] ctrl_reg;
  reg [7:0] cfg_reg;
  reg [23:0] chan_buf_reg;
  reg chan_pend_reg;
  reg [23:0] chan_reg;
  reg [15:0] ref_buf_reg;
  reg ref_pend_reg;
  reg [15:0] ref_stage_reg;
  reg ref_stage_pend_reg;
  reg [15:0] ref_reg;
  // Dual-modulus path, lock detect and APB read state
  reg [6:0] pre_cnt_reg;
  reg [5:0] swallow_reg;
  reg standby_d_reg;
  reg ref_tc_d_reg;
  reg vco_tc_d_reg;
  reg lock_reg;
  reg [31:0] prdata_reg;
  reg slverr_reg;

  wire sclk_rise;
  wire frame_start;
  wire frame_end;
  wire ref_edge;
  wire rf_edge;
  wire standby;
  wire restart;
  wire pre_pulse;
  wire [6:0] pre_mod;
  wire ref_tc;
  wire main_tc;
  wire chan_loading;
  wire [12:0] ref_ratio;
  wire apb_wr;
  wire apb_setup;
  reg [31:0] rd_mux;
  reg rd_err;

  // Divide value 1 passes through; 0, 2, 3 and 4 are raised to the minimum
  function [12:0] ref_clamp;
    input [15:0] v;
    begin
      if (v[12:0] == 13'h0001) begin
        ref_clamp = 13'h0001;
      end else if (v[12:0] < `PLLSP_REF_MIN) begin
        ref_clamp = `PLLSP_REF_MIN;
      end else begin
        ref_clamp = v[12:0];
      end
    end
  endfunction

  // Two flops before any logic; the third stage feeds edge detection and, for the reference pin, also ref_out_o
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sclk_sync_reg <= 3'h0;
      fs_sync_reg <= 3'h7;
      din_sync_reg <= 2'h0;
      ref_sync_reg <= 3'h0;
      rf_sync_reg <= 3'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], ser_clk_i};
      fs_sync_reg <= {fs_sync_reg[1:0], frame_select_n_i};
      din_sync_reg <= {din_sync_reg[0], ser_data_i};
      ref_sync_reg <= {ref_sync_reg[1:0], ref_in_i};
      rf_sync_reg <= {rf_sync_reg[1:0], rf_in_i};
    end
  end

  // Oversampling at 50 cycles per fastest bit leaves wide margin
  assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
  assign frame_start = ~fs_sync_reg[1] & fs_sync_reg[2];
  assign frame_end = fs_sync_reg[1] & ~fs_sync_reg[2];
  assign ref_edge = ref_sync_reg[1] & ~ref_sync_reg[2];
  assign rf_edge = rf_sync_reg[1] & ~rf_sync_reg[2];

  // Shift in on rising serial clock while the frame is open; count bits
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shift_reg <= 24'h000000;
      bit_cnt_reg <= 6'h00;
      dout_reg <= 1'b0;
    end else if (frame_start) begin
      bit_cnt_reg <= 6'h00;
    end else if (sclk_rise && !fs_sync_reg[1] && ctrl_reg[`PLLSP_CTRL_PORT_EN]) begin
      shift_reg <= {shift_reg[22:0], din_sync_reg[1]};
      dout_reg <= shift_reg[23]; // Bit pushed out feeds the next device
      if (bit_cnt_reg != 6'h3F) begin
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
      end
    end
  end

  // Length alone routes the frame, so no steering bits are spent
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_reg <= `PLLSP_CFG_RESET;
      chan_buf_reg <= `PLLSP_CHAN_RESET;
      chan_pend_reg <= 1'b0;
      chan_reg <= `PLLSP_CHAN_RESET;
      ref_buf_reg <= `PLLSP_REF_RESET;
      ref_pend_reg <= 1'b0;
      ref_stage_reg <= `PLLSP_REF_RESET;
      ref_stage_pend_reg <= 1'b0;
      ref_reg <= `PLLSP_REF_RESET;
    end else begin
      if (frame_end && ctrl_reg[`PLLSP_CTRL_PORT_EN]) begin
        case (bit_cnt_reg)
          `PLLSP_LEN_CFG: begin
            cfg_reg <= shift_reg[7:0]; // Gain, standby and output control
          end
          `PLLSP_LEN_REF: begin
            ref_buf_reg <= shift_reg[15:0];
          end
          `PLLSP_LEN_CHAN: begin
            chan_buf_reg <= shift_reg; // Whole retune in three bytes
          end
          default: begin
          end
        endcase
      end
      // Pending flags: a new frame wins over the commit in the same cycle
      if (frame_end && ctrl_reg[`PLLSP_CTRL_PORT_EN] && bit_cnt_reg == `PLLSP_LEN_CHAN) begin
        chan_pend_reg <= 1'b1;
      end else if (chan_pend_reg && !chan_loading) begin
        chan_pend_reg <= 1'b0;
      end
      if (frame_end && ctrl_reg[`PLLSP_CTRL_PORT_EN] && bit_cnt_reg == `PLLSP_LEN_REF) begin
        ref_pend_reg <= 1'b1;
      end else if (chan_pend_reg && !chan_loading) begin
        ref_pend_reg <= 1'b0;
      end
      // Channel commit skips reload cycles to avoid a torn value
      if (chan_pend_reg && !chan_loading) begin
        chan_reg <= chan_buf_reg;
        if (ref_pend_reg) begin
          ref_stage_reg <= ref_buf_reg; // Second buffer moves with channel
        end
      end
      // Staged reference lands only outside its own reload
      if (chan_pend_reg && !chan_loading && ref_pend_reg) begin
        ref_stage_pend_reg <= 1'b1;
      end else if (ref_stage_pend_reg && !ref_tc) begin
        ref_stage_pend_reg <= 1'b0;
      end
      if (ref_stage_pend_reg && !ref_tc) begin
        ref_reg <= ref_stage_reg;
      end
    end
  end

  // Standby from the configuration word or from software
  assign standby = cfg_reg[`PLLSP_CFG_STANDBY] | ctrl_reg[`PLLSP_CTRL_FORCE_SBY];
  assign restart = standby_d_reg & ~standby;

  // Prescaler modulus follows the swallow counter
  assign pre_mod = (swallow_reg != 6'h00) ? `PLLSP_PRE_HIGH : `PLLSP_PRE_LOW;
  assign pre_pulse = rf_edge & ~standby & (pre_cnt_reg == pre_mod - 7'h01);
  assign chan_loading = main_tc | restart;
  assign ref_ratio = ref_clamp(ref_reg);

  // Exit from standby restarts every counter in the same cycle
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      standby_d_reg <= 1'b0;
      pre_cnt_reg <= 7'h00;
      swallow_reg <= 6'h00;
    end else begin
      standby_d_reg <= standby;
      if (restart || pre_pulse) begin
        pre_cnt_reg <= 7'h00;
      end else if (rf_edge && !standby) begin
        pre_cnt_reg <= pre_cnt_reg + 7'h01;
      end
      // Swallow field loads with each main reload, then counts down
      if (chan_loading) begin
        swallow_reg <= chan_reg[`PLLSP_CHAN_A_HI:`PLLSP_CHAN_A_LO];
      end else if (pre_pulse && swallow_reg != 6'h00) begin
        swallow_reg <= swallow_reg - 6'h01;
      end
    end
  end

  // Reference counter on 13 bits, counting reference edges
  pllsp_divider #(
    .W(13)
  ) u_ref_div (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .restart_i(restart),
    .count_i(ref_edge & ~standby),
    .ratio_i(ref_ratio),
    .tc_o(ref_tc)
  );

  // Main counter of 12 bits: 64*N + A reaches 262143
  pllsp_divider #(
    .W(12)
  ) u_main_div (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .restart_i(restart),
    .count_i(pre_pulse),
    .ratio_i(chan_reg[`PLLSP_CHAN_N_HI:`PLLSP_CHAN_N_LO]),
    .tc_o(main_tc)
  );

  // Divider pulses registered; lock while both arrive in the same pair of cycles
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_tc_d_reg <= 1'b0;
      vco_tc_d_reg <= 1'b0;
      lock_reg <= 1'b0;
    end else begin
      ref_tc_d_reg <= ref_tc;
      vco_tc_d_reg <= main_tc;
      if (ref_tc || main_tc) begin
        lock_reg <= (ref_tc | ref_tc_d_reg) & (main_tc | vco_tc_d_reg);
      end
    end
  end

  // Unused outputs held inactive when switched off
  assign ref_div_o = ref_tc_d_reg;
  assign vco_div_o = vco_tc_d_reg;
  assign ref_out_o = ref_sync_reg[2] & ~cfg_reg[`PLLSP_CFG_REF_OFF] & ~standby;
  assign lock_detect_o = lock_reg & ~cfg_reg[`PLLSP_CFG_LD_OFF];
  assign pd_gain_o = cfg_reg[`PLLSP_CFG_GAIN_HI:`PLLSP_CFG_GAIN_LO];
  assign output_a_o = cfg_reg[`PLLSP_CFG_DOUT] ? dout_reg : cfg_reg[`PLLSP_CFG_OUTA];
  // Open-drain output only ever pulls low
  assign output_b_o = 1'b0;
  assign output_b_oe_o = ~cfg_reg[`PLLSP_CFG_OUTB];

  // APB: zero wait states, read data captured in the setup cycle
  assign apb_setup = psel_i & ~penable_i;
  assign apb_wr = psel_i & penable_i & pwrite_i;
  assign pready_o = 1'b1;
  assign prdata_o = prdata_reg;
  assign pslverr_o = slverr_reg & psel_i & penable_i;

  // Read decode; unmapped offsets answer with an error and zero data
  always @* begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    case (paddr_i)
      `PLLSP_OFF_CTRL: rd_mux = {30'h0, ctrl_reg};
      `PLLSP_OFF_STATUS: rd_mux = {24'h000000, lock_reg, standby, ref_stage_pend_reg,
                                   ref_pend_reg, chan_pend_reg, ~fs_sync_reg[1], 2'h0};
      `PLLSP_OFF_CFG: rd_mux = {24'h000000, cfg_reg};
      `PLLSP_OFF_CHAN: rd_mux = {8'h00, chan_reg};
      `PLLSP_OFF_REF: rd_mux = {16'h0000, ref_reg};
      default: rd_err = 1'b1;
    endcase
  end

  // Only the control register is writable; other writes to mapped offsets are dropped
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_reg <= `PLLSP_CTRL_RESET;
      prdata_reg <= 32'h00000000;
      slverr_reg <= 1'b0;
    end else begin
      if (apb_setup) begin
        prdata_reg <= pwrite_i ? 32'h00000000 : rd_mux;
        slverr_reg <= rd_err;
      end
      if (apb_wr && paddr_i == `PLLSP_OFF_CTRL) begin
        ctrl_reg <= pwdata_i[1:0];
      end
    end
  end
endmodule

// ### tb/pllsp_core_monitor.sv
/* Checker for the synthesizer programming logic: output relations seen at the ports.
   Assumes it is bound to pllsp_core and that APB reads complete with zero wait states. */
`timescale 1ns/10ps
`include "pllsp_regs.vh"
module pllsp_core_monitor (
  input wire core_clk_i,
  input wire resetn_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] prdata_o,
  input wire ref_out_o,
  input wire ref_div_o,
  input wire vco_div_o,
  input wire lock_detect_o,
  input wire [1:0] pd_gain_o,
  input wire output_a_o,
  input wire output_b_o,
  input wire output_b_oe_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  // Completed read; read data stands during the access phase
  sequence s_read(a);
    psel_i && penable_i && !pwrite_i && paddr_i == a;
  endsequence
  sequence s_cfg_read;
    s_read(`PLLSP_OFF_CFG);
  endsequence
  // Outputs must follow the configuration word that software can read back
  a_gain_field: assert property (s_cfg_read |-> pd_gain_o == prdata_o[6:5])
    else $error("gain output differs from configuration");
  a_ref_off: assert property ((s_cfg_read ##0 prdata_o[1]) |-> !ref_out_o)
    else $error("reference output active while switched off");
  a_lock_off: assert property ((s_cfg_read ##0 prdata_o[0]) |-> !lock_detect_o)
    else $error("lock output active while switched off");
  a_outb_release: assert property (s_cfg_read |-> !output_b_o && output_b_oe_o == !prdata_o[2])
    else $error("open drain output does not follow configuration");
  a_aux_level: assert property ((s_cfg_read ##0 !prdata_o[4]) |-> output_a_o == prdata_o[3])
    else $error("push pull output level differs from configuration");
  // Terminal counts are single-cycle pulses; a stuck pulse would double count
  a_ref_pulse: assert property ($rose(ref_div_o) |=> !ref_div_o [*2])
    else $error("reference pulse longer than one cycle");
  a_vco_pulse: assert property ($rose(vco_div_o) |=> !vco_div_o [*8])
    else $error("main divider pulse too long or too close");
  a_standby_quiet: assert property ((s_read(`PLLSP_OFF_STATUS) ##0 prdata_o[6]) |->
    !ref_out_o && !ref_div_o && !vco_div_o) else $error("activity during standby");
endmodule

bind pllsp_core pllsp_core_monitor i_mon (.core_clk_i, .resetn_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .prdata_o, .ref_out_o, .ref_div_o, .vco_div_o, .lock_detect_o,
  .pd_gain_o, .output_a_o, .output_b_o, .output_b_oe_o);

// ### tb/pllsp_host_model.sv
/* Host model for the serial programming port: one frame of a given bit count, MSB first.
   Assumes the bench calls send; the link clock rests low between frames. */
`timescale 1ns/10ps
module pllsp_host_model (
  output logic ser_clk_o,
  output logic ser_data_o,
  output logic frame_select_n_o
);
  initial begin
    ser_clk_o = 1'b0;
    ser_data_o = 1'b0;
    frame_select_n_o = 1'b1;
  end
  // Frame length alone names the register, so no address bits are sent
  task automatic send(input logic [31:0] v, input int nb);
    frame_select_n_o = 1'b0;
    for (int i = nb - 1; i >= 0; i--) begin
      ser_data_o = v[i];
      #80 ser_clk_o = 1'b1;
      #80 ser_clk_o = 1'b0;
    end
    #80 frame_select_n_o = 1'b1;
    // Released line shows the inverse, so a stale level is never mistaken for data
    ser_data_o = ~ser_data_o;
    #160;
  endtask
endmodule

// ### tb/testbench.sv
/* Self-checking bench for pllsp_core: APB reads, serial frames and divider periods.
   Assumes the host model and the bound checker are compiled alongside. */
`timescale 1ns/10ps
`include "pllsp_regs.vh"
module testbench;
  logic core_clk_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h00000000;
  logic ref_in_i = 0, rf_in_i = 0, clk_on = 0, ph = 0;
  wire [31:0] prdata_o;
  wire [1:0] pd_gain_o;
  wire pready_o, pslverr_o, ser_data_i, ser_clk_i, frame_select_n_i, ref_out_o, ref_div_o;
  wire vco_div_o, lock_detect_o, output_a_o, output_b_o, output_b_oe_o;
  int num_errors = 0, samples_checked = 0, rf_cnt = 0, ref_cnt = 0;
  logic [32:0] exp_q[$], msk_q[$], m, e;
  logic [11:0] n;
  logic [5:0] a;
  logic [1:0] g;
  logic [31:0] v;
  pllsp_core i_dut (.core_clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .ser_data_i, .ser_clk_i, .frame_select_n_i,
    .ref_in_i, .rf_in_i, .ref_out_o, .ref_div_o, .vco_div_o, .lock_detect_o, .pd_gain_o,
    .output_a_o, .output_b_o, .output_b_oe_o);
  pllsp_host_model i_host (.ser_clk_o(ser_clk_i), .ser_data_o(ser_data_i),
    .frame_select_n_o(frame_select_n_i));
  initial forever #2.5 core_clk_i = ~core_clk_i;
  // Pin clocks at a quarter of the core rate, well inside the synchroniser limit
  always @(posedge core_clk_i) if (clk_on) begin
    ph <= ~ph;
    if (ph) begin
      ref_in_i <= ~ref_in_i;
      rf_in_i <= ~rf_in_i;
    end
  end
  always @(posedge ref_in_i) ref_cnt++;
  always @(posedge rf_in_i) rf_cnt++;
  task check(input logic [32:0] got, input logic [32:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Read watcher takes the oldest note at every completed read
  always @(posedge core_clk_i) if (psel_i && penable_i && !pwrite_i && pready_o) begin
    if (exp_q.size() == 0) begin
      check(33'h0, 33'h1, "read with no note");
    end else begin
      m = msk_q.pop_front();
      e = exp_q.pop_front();
      check({pslverr_o, prdata_o} & m, e, "read");
    end
  end
  // Setup cycle, then access held until pready is sampled high
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= ad;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do @(posedge core_clk_i); while (pready_o !== 1'b1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task rd(input logic [7:0] ad, input logic [32:0] ex, input logic [32:0] mk = {33{1'b1}});
    exp_q.push_back(ex);
    msk_q.push_back(mk);
    apb(1'b0, ad, 32'h00000000);
  endtask
  // Register update needs the synchroniser plus the commit cycle
  task frame(input logic [31:0] fv, input int nb);
    i_host.send(fv, nb);
    repeat (8) @(posedge core_clk_i);
  endtask
  task pulse(input logic sel);
    for (int k = 0; k < 40000; k++) begin
      @(posedge core_clk_i);
      if ((sel ? vco_div_o : ref_div_o) === 1'b1) break;
    end
  endtask
  // First pulse may still use the old ratio, so count between the next two
  task measure(input logic sel, input int exp);
    int s0;
    pulse(sel);
    s0 = sel ? rf_cnt : ref_cnt;
    pulse(sel);
    check(33'((sel ? rf_cnt : ref_cnt) - s0), 33'(exp), "divider period");
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #450000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    void'($urandom(58));
    repeat (10) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    rd(`PLLSP_OFF_CTRL, 33'h1);
    rd(`PLLSP_OFF_CHAN, 33'h40);
    rd(`PLLSP_OFF_REF, 33'h1);
    rd(8'h14, {1'b1, 32'h0});
    // Configuration frame: random gain, output A high, output B released
    g = 2'($urandom);
    v = {25'h0, g, 5'h0C};
    frame(v, 8);
    rd(`PLLSP_OFF_CFG, 33'(v));
    check(33'(pd_gain_o), 33'(g), "gain");
    check(33'({output_a_o, output_b_oe_o}), 33'h2, "outputs");
    apb(1'b1, `PLLSP_OFF_CFG, 32'hFF);
    rd(`PLLSP_OFF_CFG, 33'(v));
    // Data-out mode, then a 32-bit frame that matches no register
    frame(32'h10, 8);
    v = $urandom;
    frame(v, 32);
    check(33'(output_a_o), 33'(v[24]), "chained data");
    rd(`PLLSP_OFF_CFG, 33'h10);
    // Reference ratio stays pending until a channel frame arrives
    frame(32'h5, 16);
    rd(`PLLSP_OFF_STATUS, 33'h10, 33'h10);
    rd(`PLLSP_OFF_REF, 33'h1);
    n = 12'(1 + $urandom % 4);
    a = 6'($urandom % (n + 1));
    frame({n, a}, 24);
    rd(`PLLSP_OFF_CHAN, 33'({n, a}));
    rd(`PLLSP_OFF_REF, 33'h5);
    clk_on <= 1'b1;
    measure(1'b0, 5);
    measure(1'b1, 64 * n + a);
    // Retune while counters run, with a ratio of one
    frame(32'h1, 16);
    n = 12'(1 + $urandom % 4);
    a = 6'($urandom % (n + 1));
    frame({n, a}, 24);
    measure(1'b0, 1);
    measure(1'b1, 64 * n + a);
    frame(32'h3, 8);
    rd(`PLLSP_OFF_CFG, 33'h3);
    frame(32'h80, 8);
    rd(`PLLSP_OFF_STATUS, 33'h40, 33'h40);
    // Equal ratios loaded in standby; the restart must align both dividers
    frame(32'(64 * n + a), 16);
    frame({n, a}, 24);
    frame(32'h0, 8);
    measure(1'b0, 64 * n + a);
    check(33'(lock_detect_o), 33'h1, "lock after restart");
    // Reference output follows its pin again once switched on
    @(posedge ref_in_i);
    repeat (4) @(posedge core_clk_i);
    check(33'(ref_out_o), 33'h1, "reference output");
    // Frames are ignored while the port is disabled
    apb(1'b1, `PLLSP_OFF_CTRL, 32'h0);
    frame(32'h60, 8);
    apb(1'b1, `PLLSP_OFF_CTRL, 32'h1);
    rd(`PLLSP_OFF_CFG, 33'h0);
    repeat (10) @(posedge core_clk_i);
    report_and_stop();
  end
endmodule
